/* File: wdtc_assertions.sv */
// Port checker for the watchdog block.
// Assumes one mclk domain and the wdtc_top ports.
`timescale 1ns/1ps
module wdtc_chk
   import wdtc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic chip_rst_n,
   input wire logic always_on_fuse,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic wdog_reset_pulse,
   input wire logic wdog_active
);
   // ****
   // Properties
   // ****
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic ctl_wr;
   // Writes that collide with a reset are left unjudged
   assign ctl_wr = reg_wr && reg_addr == OFS_WATCHDOG_CONTROL && chip_rst_n && !wdog_reset_pulse;
   sequence s_open;
      ctl_wr && reg_wdata[4:3] == 2'h3 && !always_on_fuse;
   endsequence
   sequence s_off;
      ctl_wr && reg_wdata[4:3] == 2'h0;
   endsequence
   property p_rsvd;
      $past(reg_rd && reg_addr == OFS_WATCHDOG_CONTROL) |-> reg_rdata[7:5] == 3'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
   property p_pulse_one;
      wdog_reset_pulse |=> !wdog_reset_pulse;
   endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
   property p_lvl2_on;
      always_on_fuse |-> wdog_active;
   endproperty
   a_lvl2_on: assert property (p_lvl2_on) else $error("level two not enabled");
   property p_lvl2_rd;
      $past(reg_rd && reg_addr == OFS_WATCHDOG_CONTROL && always_on_fuse) |-> reg_rdata[3];
   endproperty
   a_lvl2_rd: assert property (p_lvl2_rd) else $error("level two enable reads zero");
   property p_cause;
      $rose(wdog_reset_pulse) |-> $past(wdog_active);
   endproperty
   a_cause: assert property (p_cause) else $error("pulse while disabled");
   property p_lvl1_drop;
      wdog_reset_pulse && !always_on_fuse |=> !wdog_active;
   endproperty
   a_lvl1_drop: assert property (p_lvl1_drop) else $error("still enabled after reset");
   property p_enable;
      ctl_wr && reg_wdata[3] |=> wdog_active;
   endproperty
   a_enable: assert property (p_enable) else $error("enable write ignored");
   property p_disable;
      s_open ##1 !reg_wr [*3] ##1 s_off |=> !wdog_active;
   endproperty
   a_disable: assert property (p_disable) else $error("disable in window ignored");
   property p_late;
      s_open ##1 !reg_wr [*4] ##1 (ctl_wr && reg_wdata[4:3] == 2'h0 && wdog_active) |=> wdog_active;
   endproperty
   a_late: assert property (p_late) else $error("disable after window taken");
endmodule
bind wdtc_top wdtc_chk u_chk (.mclk(mclk), .rst_n(rst_n), .chip_rst_n(chip_rst_n),
   .always_on_fuse(always_on_fuse), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wdog_reset_pulse(wdog_reset_pulse),
   .wdog_active(wdog_active));

/* File: wdtc_counter.sv */
// Watchdog count of oscillator ticks with synchronous clear.
// Assumes tick is a one-cycle enable in the system clock domain.
`timescale 1ns/1ps
module wdtc_counter
   import wdtc_pkg::*;
#(
   parameter int W = CNT_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   output logic expire
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic expire_q;
   logic expire_d;

   always_comb begin
      cnt_d = cnt_q;
      expire_d = 1'b0;
      if (clr) begin
         cnt_d = '0;
      end else if (tick) begin
         // Greater-or-equal so a shorter period chosen mid-count still expires
         if (cnt_q >= limit - W'(1)) begin
            cnt_d = '0;
            expire_d = 1'b1;
         end else begin
            cnt_d = cnt_q + W'(1);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_q <= '0;
         expire_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         expire_q <= expire_d;
      end
   end

   assign expire = expire_q;

endmodule

/* File: wdtc_osc_div.sv */
// Divider that stands in for the watchdog's own oscillator.
// Assumes one system clock; emits a one-cycle tick at the oscillator rate.
`timescale 1ns/1ps
module wdtc_osc_div
   import wdtc_pkg::*;
#(
   parameter int DIV = OSC_DIV
) (
   input wire logic mclk,
   input wire logic rst_n,
   output logic tick
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;

   always_comb begin
      if (cnt_q == 8'(DIV - 1)) begin
         cnt_d = 8'h00;
      end else begin
         cnt_d = cnt_q + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Free running: it never stops, so the time base is independent of software
   assign tick = (cnt_q == 8'(DIV - 1));

endmodule

/* File: wdtc_pkg.sv */
// Constants, field layout and carrier types for the watchdog timer block.
// Assumes a single 10 MHz system clock; the watchdog tick is derived from it.
package wdtc_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int MCLK_HZ = 10_000_000;
   localparam int WDOG_OSC_HZ = 1_000_000;
   localparam int OSC_DIV = MCLK_HZ / WDOG_OSC_HZ;
   localparam int UNLOCK_CYCLES = 4;
   localparam int TIMEOUT_BASE_CYCLES = 16384;
   localparam int CNT_W = 22;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_WATCHDOG_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_WDOG_STATUS = 4'h1;
   localparam int POS_CHANGE_UNLOCK = 4;
   localparam int POS_WDOG_ON = 3;
   localparam int POS_TIMEOUT_SELECT = 0;
   localparam int POS_WDOG_CAUSE_FLAG = 3;
   localparam logic [7:0] RST_WATCHDOG_CONTROL = 8'h00;
   localparam logic [7:0] RST_WDOG_STATUS = 8'h00;

   // Shift applied to the base count for each select code; code 3 taken as 128K
   localparam logic [23:0] TIMEOUT_SHIFTS = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef struct packed {
      logic [2:0] rsvd;
      logic change_unlock;
      logic wdog_on;
      logic [2:0] timeout_select;
   } wdtc_ctrl_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdtc_bus_s;

endpackage

/* File: wdtc_tb_top.sv */
// Self-checking bench for the watchdog block.
// Assumes short counts: base 4 ticks, one tick every 2 clocks.
`timescale 1ns/1ps
module wdtc_tb_top
   import wdtc_pkg::*;
;
   // ****
   // Stimulus and checks
   // ****
   logic mclk = 0, rst_n = 0, chip_rst_n = 1, always_on_fuse = 0, kick_instruction = 0;
   logic reg_wr = 0, reg_rd = 0, wdog_reset_pulse, wdog_active;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   int errors = 0, samples_checked = 0, pulses = 0, n, p0;
   int codes[$];
   always #50 mclk = ~mclk;
   always @(posedge mclk) if (wdog_reset_pulse === 1'b1) pulses++;
   wdtc_top #(.BASE_CYCLES(4), .DIV(2)) u_dut (.mclk(mclk), .rst_n(rst_n), .chip_rst_n(chip_rst_n),
      .always_on_fuse(always_on_fuse), .kick_instruction(kick_instruction), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .wdog_reset_pulse(wdog_reset_pulse), .wdog_active(wdog_active));
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 check(what, reg_rdata, exp);
   endtask
   task reset_dut(input logic fuse);
      @(posedge mclk);
      rst_n <= 1'b0;
      always_on_fuse <= fuse;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
   endtask
   // Pulse must land inside the tick-phase slack of the period
   task wait_expiry(input int lim, input int n0);
      n = n0;
      while (wdog_reset_pulse !== 1'b1 && n < 1200) begin
         @(posedge mclk);
         #1 n++;
      end
      check("period", 8'(n >= 2 * (lim - 1) && n <= 2 * lim + 4), 8'h01);
      @(posedge mclk);
      #1 check("off_after", 8'(wdog_active), 8'h00);
      rd(OFS_WDOG_STATUS, 8'h08, "cause");
      wr(OFS_WDOG_STATUS, 8'h00);
      rd(OFS_WDOG_STATUS, 8'h00, "cause_clr");
      rd(OFS_WATCHDOG_CONTROL, 8'h00, "ctrl_clr");
   endtask
   initial begin
      n = $urandom(48);
      reset_dut(1'b0);
      check("active_rst", 8'(wdog_active), 8'h00);
      rd(OFS_WATCHDOG_CONTROL, RST_WATCHDOG_CONTROL, "ctrl_rst");
      rd(4'hf, 8'h00, "unmapped");
      // Kick held high so the short test period cannot expire mid-sequence
      kick_instruction <= 1'b1;
      wr(OFS_WATCHDOG_CONTROL, 8'he9);
      rd(OFS_WATCHDOG_CONTROL, 8'h08, "sel_locked");
      wr(OFS_WATCHDOG_CONTROL, 8'h00);
      rd(OFS_WATCHDOG_CONTROL, 8'h08, "off_locked");
      wr(OFS_WATCHDOG_CONTROL, 8'h18);
      repeat (3) @(posedge mclk);
      wr(OFS_WATCHDOG_CONTROL, 8'h00);
      rd(OFS_WATCHDOG_CONTROL, 8'h08, "late");
      wr(OFS_WATCHDOG_CONTROL, 8'h18);
      repeat (2) @(posedge mclk);
      wr(OFS_WATCHDOG_CONTROL, 8'h05);
      rd(OFS_WATCHDOG_CONTROL, 8'h05, "off_sel");
      kick_instruction <= 1'b0;
      for (int c = 0; c < 8; c++) codes.insert($urandom_range(0, codes.size()), c);
      while (codes.size() > 0) begin
         p0 = codes.pop_front();
         wr(OFS_WATCHDOG_CONTROL, 8'h08);
         wr(OFS_WATCHDOG_CONTROL, 8'h18);
         wr(OFS_WATCHDOG_CONTROL, 8'(8'h08 | p0));
         wait_expiry(4 << p0, 4);
      end
      wr(OFS_WATCHDOG_CONTROL, 8'h08);
      p0 = pulses;
      repeat (12) begin
         repeat ($urandom_range(1, 4)) @(posedge mclk);
         kick_instruction <= 1'b1;
         @(posedge mclk);
         kick_instruction <= 1'b0;
      end
      check("kicked", 8'(pulses - p0), 8'h00);
      wait_expiry(4, 0);
      wr(OFS_WATCHDOG_CONTROL, 8'h0f);
      chip_rst_n <= 1'b0;
      @(posedge mclk);
      chip_rst_n <= 1'b1;
      rd(OFS_WATCHDOG_CONTROL, 8'h00, "chip_rst");
      kick_instruction <= 1'b1;
      reset_dut(1'b1);
      check("lvl2_on", 8'(wdog_active), 8'h01);
      wr(OFS_WATCHDOG_CONTROL, 8'h00);
      rd(OFS_WATCHDOG_CONTROL, 8'h08, "lvl2_keep");
      wr(OFS_WATCHDOG_CONTROL, 8'h18);
      wr(OFS_WATCHDOG_CONTROL, 8'h02);
      rd(OFS_WATCHDOG_CONTROL, 8'h0a, "lvl2_sel");
      kick_instruction <= 1'b0;
      p0 = pulses;
      repeat (40) @(posedge mclk);
      check("lvl2_pulse", 8'(pulses - p0), 8'h01);
      check("lvl2_after", 8'(wdog_active), 8'h01);
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      tally_and_finish;
   end
endmodule

/* File: wdtc_top.sv */
// Watchdog timer with timed unlock for disable and time-out change.
// Assumes synchronous inputs, a 10 MHz mclk and a single-cycle register port.
//
// How it works
// - Counter ticks from separate 1 MHz time base
// - Kick, disable or chip reset restart count
// - Elapsed period without kick resets the chip
// - Three-bit select picks one of eight periods
// - Fuse picks level one or level two
// - Unlock bit self-clears four clocks after set
// - Disabling only allowed while unlock bit set
// - Period changes only inside unlock window
// - Level one enables freely, no unlock needed
// - Level two stays enabled, reads enabled always
// - Level two ignores enable in second write
// - Control bits seven to five read zero
// - Expiry gives a one-cycle reset pulse
// - Cause flag set by expiry, cleared by software
`timescale 1ns/1ps
module wdtc_top
   import wdtc_pkg::*;
#(
   parameter int BASE_CYCLES = TIMEOUT_BASE_CYCLES,
   parameter int DIV = OSC_DIV
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic chip_rst_n,
   input wire logic always_on_fuse,
   input wire logic kick_instruction,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic wdog_reset_pulse,
   output logic wdog_active
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [CNT_W-1:0] period_cycles(input logic [2:0] sel);
      logic [2:0] sh;
      sh = TIMEOUT_SHIFTS[3*sel +: 3];
      period_cycles = CNT_W'(BASE_CYCLES) << sh;
   endfunction

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   wdtc_bus_s bus;
   wdtc_ctrl_s wr_ctrl;
   logic level2;
   logic tick;
   logic expire;
   logic chip_reset;
   logic wr_ctrl_hit;
   logic wr_stat_hit;

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign wr_ctrl = wdtc_ctrl_s'(bus.wdata);
   assign level2 = always_on_fuse;
   assign wr_ctrl_hit = bus.wr && hit(bus.addr, OFS_WATCHDOG_CONTROL);
   assign wr_stat_hit = bus.wr && hit(bus.addr, OFS_WDOG_STATUS);

   // ****************************************************************
   // Control register and unlock window
   // ****************************************************************
   logic on_q;
   logic on_d;
   logic [2:0] sel_q;
   logic [2:0] sel_d;
   logic unlock_q;
   logic unlock_d;
   logic [2:0] ucnt_q;
   logic [2:0] ucnt_d;
   logic on_eff;

   // Level two forces the enable regardless of the stored bit
   assign on_eff = on_q | level2;

   always_comb begin
      on_d = on_q;
      sel_d = sel_q;
      unlock_d = unlock_q;
      ucnt_d = ucnt_q;
      if (unlock_q) begin
         if (ucnt_q == 3'h0) begin
            unlock_d = 1'b0;
         end else begin
            ucnt_d = ucnt_q - 3'h1;
         end
      end
      if (wr_ctrl_hit) begin
         if (unlock_q) begin
            sel_d = wr_ctrl.timeout_select;
            on_d = level2 ? 1'b1 : wr_ctrl.wdog_on;
         end else begin
            // Outside the window a zero is ignored, a one still enables
            on_d = on_q | wr_ctrl.wdog_on;
         end
         // A new opening write restarts the window; it needs both bits high
         if (wr_ctrl.change_unlock && wr_ctrl.wdog_on) begin
            unlock_d = 1'b1;
            ucnt_d = 3'(UNLOCK_CYCLES - 1);
         end else if (unlock_q) begin
            unlock_d = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || chip_reset) begin
         on_q <= RST_WATCHDOG_CONTROL[POS_WDOG_ON];
         sel_q <= RST_WATCHDOG_CONTROL[POS_TIMEOUT_SELECT +: 3];
         unlock_q <= RST_WATCHDOG_CONTROL[POS_CHANGE_UNLOCK];
         ucnt_q <= 3'h0;
      end else begin
         on_q <= on_d;
         sel_q <= sel_d;
         unlock_q <= unlock_d;
         ucnt_q <= ucnt_d;
      end
   end

   // ****************************************************************
   // Time base and count
   // ****************************************************************
   wdtc_osc_div #(
      .DIV(DIV)
   ) u_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(tick)
   );

   // One clock domain: kicks and disables land directly, nothing to lose
   wdtc_counter #(
      .W(CNT_W)
   ) u_cnt (
      .mclk(mclk),
      .rst_n(rst_n),
      .clr(kick_instruction || !on_eff || chip_reset),
      .tick(tick && on_eff),
      .limit(period_cycles(sel_q)),
      .expire(expire)
   );

   // ****************************************************************
   // Reset pulse and cause flag
   // ****************************************************************
   logic pulse_q;
   logic pulse_d;
   logic cause_q;
   logic cause_d;

   assign chip_reset = !chip_rst_n || pulse_q;

   always_comb begin
      pulse_d = expire && on_eff;
      cause_d = cause_q;
      if (wr_stat_hit && !bus.wdata[POS_WDOG_CAUSE_FLAG]) begin
         cause_d = 1'b0;
      end
      // Expiry beats a clear landing in the same cycle
      if (pulse_q) begin
         cause_d = 1'b1;
      end
   end

   // The cause flag survives chip resets; only power-on reset or a software write of zero clears it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pulse_q <= 1'b0;
         cause_q <= RST_WDOG_STATUS[POS_WDOG_CAUSE_FLAG];
      end else begin
         pulse_q <= pulse_d;
         cause_q <= cause_d;
      end
   end

   assign wdog_reset_pulse = pulse_q;
   assign wdog_active = on_eff;

   // ****************************************************************
   // Read path
   // ****************************************************************
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   wdtc_ctrl_s rd_ctrl;

   always_comb begin
      rd_ctrl = '0;
      rd_ctrl.change_unlock = unlock_q;
      rd_ctrl.wdog_on = on_eff;
      rd_ctrl.timeout_select = sel_q;
      rdata_d = 8'h00;
      if (bus.rd) begin
         if (hit(bus.addr, OFS_WATCHDOG_CONTROL)) begin
            rdata_d = rd_ctrl;
         end else if (hit(bus.addr, OFS_WDOG_STATUS)) begin
            rdata_d[POS_WDOG_CAUSE_FLAG] = cause_q;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

endmodule
